// ### tucs_ctrl.sv
// Local design decision: the strobed register port.
module tucs_ctrl (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// register port
	input  wire logic [9:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// trigger units
	input  wire logic [11:0] unit_fired,
	input  wire logic [11:0] event_notify_option,
	input  wire logic [11:0] unit_late,
	output logic      [11:0] unit_enable_bits,
	output logic      [11:0] unit_soft_reset_bits,
	output logic      [11:0] unit_error_flags,
	// interrupt
	output logic             irq
);

	logic [11:0] done_ff;
	logic [11:0] en_ff;
	logic [11:0] srst_ff;
	logic [11:0] err_ff;
	logic [11:0] mask_ff;
	logic [15:0] rdata_ff;
	logic [11:0] nxt_done;
	logic [11:0] nxt_en;
	logic [11:0] nxt_err;
	logic [11:0] fire_ok;
	logic        wr_done;
	logic        wr_en;
	logic        wr_srst;
	logic        wr_mask;

	function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
		hit = (a == ofs);
	endfunction

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	assign wr_done = reg_wr && hit(reg_addr, tucs_pkg::OFS_DONE);
	assign wr_en   = reg_wr && hit(reg_addr, tucs_pkg::OFS_ENABLE);
	assign wr_srst = reg_wr && hit(reg_addr, tucs_pkg::OFS_SOFT_RESET);
	assign wr_mask = reg_wr && hit(reg_addr, tucs_pkg::OFS_IRQ_MASK);

	// fire only counts while enabled and not in reset
	assign fire_ok = unit_fired & en_ff & ~srst_ff;

	// ------------------------------------------------------------
	// done flags
	// ------------------------------------------------------------
	always_comb begin
		nxt_done = done_ff;
		if (wr_done) begin
			nxt_done = done_ff & ~reg_wdata[11:0];
		end
		nxt_done = nxt_done | (fire_ok & event_notify_option);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done_ff <= tucs_pkg::RST_UNITS;
		end else begin
			done_ff <= nxt_done;
		end
	end

	// ------------------------------------------------------------
	// enable bits
	// ------------------------------------------------------------
	always_comb begin
		nxt_en = en_ff;
		if (wr_en) begin
			nxt_en = reg_wdata[11:0];
		end
		nxt_en = nxt_en & ~fire_ok & ~srst_ff;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en_ff <= tucs_pkg::RST_UNITS;
		end else begin
			en_ff <= nxt_en;
		end
	end

	// ------------------------------------------------------------
	// error flags
	// ------------------------------------------------------------
	always_comb begin
		nxt_err = err_ff & nxt_en;
		nxt_err = nxt_err | (unit_late & en_ff & event_notify_option & ~srst_ff);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			err_ff <= tucs_pkg::RST_UNITS;
		end else begin
			err_ff <= nxt_err;
		end
	end

	// ------------------------------------------------------------
	// soft reset, one cycle then self clear
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			srst_ff <= tucs_pkg::RST_UNITS;
		end else if (wr_srst) begin
			srst_ff <= reg_wdata[11:0];
		end else begin
			srst_ff <= tucs_pkg::RST_UNITS;
		end
	end

	// ------------------------------------------------------------
	// interrupt mask
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_ff <= tucs_pkg::RST_UNITS;
		end else if (wr_mask) begin
			mask_ff <= reg_wdata[11:0];
		end
	end

	assign irq = |((done_ff | err_ff) & mask_ff);

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				tucs_pkg::OFS_ERROR:      rdata_ff <= {tucs_pkg::RSV_BITS, err_ff};
				tucs_pkg::OFS_DONE:       rdata_ff <= {tucs_pkg::RSV_BITS, done_ff};
				tucs_pkg::OFS_ENABLE:     rdata_ff <= {tucs_pkg::RSV_BITS, en_ff};
				tucs_pkg::OFS_SOFT_RESET: rdata_ff <= {tucs_pkg::RSV_BITS, srst_ff};
				tucs_pkg::OFS_IRQ_MASK:   rdata_ff <= {tucs_pkg::RSV_BITS, mask_ff};
				default:                  rdata_ff <= 16'h0000;
			endcase
		end else begin
			rdata_ff <= 16'h0000;
		end
	end

	assign reg_rdata            = rdata_ff;
	assign unit_enable_bits     = en_ff;
	assign unit_soft_reset_bits = srst_ff;
	assign unit_error_flags     = err_ff;

endmodule

// ### tucs_pkg.sv
//
// Behaviour
// - A unit's done bit is set when it fires with notify set, and writing one to it clears it.
// - A done bit raises the interrupt only when its interrupt enable bit is set.
// - Done, enable and soft reset hold one bit per unit for twelve units, bit 0 being unit 1.
// - Writing one to an enable bit starts the unit, and the bit clears itself when the unit fires.
// - A unit whose enable bit is zero is disabled and produces no trigger output.
// - Writing one to a soft reset bit forces the unit inactive and returns its settings to default.
// - A soft reset halts a running cascade and leaves the unit ready for a new setup.
// - While a soft reset bit is zero the unit works normally.
// - A done bit of zero means the unit has not yet produced its event.
// - A unit's error bit is cleared when software clears that unit's enable bit.
//
package tucs_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int           ADDR_W           = 10;
	localparam int           DATA_W           = 16;
	localparam int           UNITS            = 12;
	localparam logic [9:0]   OFS_ERROR        = 10'h200;
	localparam logic [9:0]   OFS_DONE         = 10'h204;
	localparam logic [9:0]   OFS_ENABLE       = 10'h206;
	localparam logic [9:0]   OFS_SOFT_RESET   = 10'h208;
	localparam logic [9:0]   OFS_IRQ_MASK     = 10'h20c;
	localparam logic [11:0]  RST_UNITS        = 12'h000;
	localparam logic [3:0]   RSV_BITS         = 4'h0;

endpackage

// ### tucs_chk.sv
module tucs_chk (
	// clock and register port
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [9:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// trigger units
	input wire logic [11:0] unit_fired,
	input wire logic [11:0] unit_enable_bits,
	input wire logic [11:0] unit_soft_reset_bits,
	input wire logic [11:0] unit_error_flags
);
	// ----
	// register and unit relations
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_en_write: assert property (reg_wr && reg_addr == 10'h206 && !unit_fired
		&& !unit_soft_reset_bits |=> unit_enable_bits == $past(reg_wdata[11:0]))
		else $error("enable write lost");
	a_en_fire: assert property (|(unit_fired & unit_enable_bits)
		|=> !(unit_enable_bits & $past(unit_fired))) else $error("enable kept after fire");
	a_sr_write: assert property (reg_wr && reg_addr == 10'h208
		|=> unit_soft_reset_bits == $past(reg_wdata[11:0])) else $error("soft reset missing");
	a_sr_self: assert property (|unit_soft_reset_bits && !reg_wr
		|=> !unit_soft_reset_bits) else $error("soft reset stuck");
	a_sr_stop: assert property (|unit_soft_reset_bits && !reg_wr
		|=> !(unit_enable_bits & $past(unit_soft_reset_bits))) else $error("unit not halted");
	a_err_clr: assert property (1'b1
		|=> !(unit_error_flags & ~$past(unit_enable_bits))) else $error("error not cleared");
	a_rd_rsv: assert property (reg_rd |=> reg_rdata[15:12] == 4'h0)
		else $error("reserved bits set");
	a_rd_en: assert property (reg_rd && reg_addr == 10'h206
		|=> reg_rdata == {4'h0, $past(unit_enable_bits)}) else $error("enable readback");
	cover property (|(unit_fired & unit_enable_bits));
	cover property (|unit_soft_reset_bits);
	cover property (|unit_error_flags);
endmodule
bind tucs_ctrl tucs_chk u_chk (.*);

// ### tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// stimulus and checks
	// ----
	logic        clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, irq;
	logic [9:0]  reg_addr = '0;
	logic [15:0] reg_wdata = '0, reg_rdata;
	logic [11:0] unit_fired = '0, unit_late = '0, event_notify_option = 12'hfef;
	logic [11:0] unit_enable_bits, unit_soft_reset_bits, unit_error_flags;
	int          num_errors = 0, n_checks = 0;
	logic [41:0] rows [7] = '{{10'h206, 16'hffff, 16'h0fff}, {10'h206, 16'h0000, 16'h0000},
		{10'h20c, 16'hffff, 16'h0fff}, {10'h204, 16'hffff, 16'h0000},
		{10'h208, 16'h0001, 16'h0000}, {10'h300, 16'hffff, 16'h0000},
		{10'h200, 16'hffff, 16'h0000}};
	always #50 clk = ~clk;
	tucs_ctrl dut (.*);
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		@(negedge clk);
		chk("rdata", reg_rdata, e);
	endtask
	task automatic fire(input logic [11:0] f, l);
		@(posedge clk);
		unit_fired <= f;
		unit_late <= l;
		@(posedge clk);
		unit_fired <= '0;
		unit_late <= '0;
		@(negedge clk);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		foreach (rows[i]) begin
			wr(rows[i][41:32], rows[i][31:16]);
			rd(rows[i][41:32], rows[i][15:0]);
		end
		$display("table done");
		wr(10'h206, 16'h0011);
		fire(12'h013, '0);
		chk("enable", {4'h0, unit_enable_bits}, 16'h0000);
		chk("irq", {15'h0, irq}, 16'h0001);
		rd(10'h204, 16'h0001);
		wr(10'h20c, 16'h0000);
		@(negedge clk);
		chk("irq", {15'h0, irq}, 16'h0000);
		wr(10'h204, 16'h0001);
		wr(10'h20c, 16'h0fff);
		rd(10'h204, 16'h0000);
		$display("fire done");
		wr(10'h206, 16'h0004);
		fire('0, 12'h004);
		chk("error", {4'h0, unit_error_flags}, 16'h0004);
		wr(10'h206, 16'h0000);
		repeat (2) @(negedge clk);
		chk("error", {4'h0, unit_error_flags}, 16'h0000);
		$display("error done");
		wr(10'h206, 16'h0018);
		wr(10'h208, 16'h0008);
		@(negedge clk);
		chk("softrst", {4'h0, unit_soft_reset_bits}, 16'h0008);
		rd(10'h206, 16'h0010);
		$display("soft reset done");
		@(posedge clk);
		rst_b <= 1'h0;
		@(negedge clk);
		chk("enable", {4'h0, unit_enable_bits}, 16'h0000);
		chk("error", {4'h0, unit_error_flags}, 16'h0000);
		chk("irq", {15'h0, irq}, 16'h0000);
		@(posedge clk);
		rst_b <= 1'h1;
		rd(10'h20c, 16'h0000);
		$display("reset done");
		finish_test;
	end
	initial begin
		repeat (1000) @(posedge clk);
		num_errors++;
		finish_test;
	end
endmodule
